//--- logic/cmh_consts.svh
// Constants for the channel modem control handshake block
`ifndef CMH_CONSTS_SVH
`define CMH_CONSTS_SVH
// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define CMH_OPT_OFS 12'h000
`define CMH_CFG_OFS 12'h004
`define CMH_CMD_OFS 12'h008
`define CMH_STAT_OFS 12'h00C
// ---------------------------------------------------------------
// Option register fields
// ---------------------------------------------------------------
`define CMH_OPT_TYPE_LSB 0
`define CMH_OPT_TYPE_MSB 2
`define CMH_OPT_PRIO_BIT 4
`define CMH_OPT_ACCT_BIT 5
`define CMH_OPT_STD_BIT 6
`define CMH_OPT_RST 8'h00
// ---------------------------------------------------------------
// Configuration register fields
// ---------------------------------------------------------------
`define CMH_CFG_FLOW_BIT 0
`define CMH_CFG_CLRLOSS_BIT 1
`define CMH_CFG_PVC_BIT 2
`define CMH_CFG_CONST_BIT 3
`define CMH_CFG_BUSY_BIT 4
`define CMH_CFG_DISC_BIT 5
`define CMH_CFG_BIAS_LSB 6
`define CMH_CFG_BIAS_MSB 8
`define CMH_CFG_RST 9'h000
// ---------------------------------------------------------------
// Command register bits (write one to act)
// ---------------------------------------------------------------
`define CMH_CMD_CALL_BIT 0
`define CMH_CMD_CLEAR_BIT 1
`define CMH_CMD_LOSS_BIT 2
`define CMH_CMD_FAIL_BIT 3
`define CMH_CMD_EST_BIT 4
// ---------------------------------------------------------------
// Connection type codes and timing in milliseconds
// ---------------------------------------------------------------
`define CMH_TYPE_HOLD 3'h1
`define CMH_TYPE_RING 3'h2
`define CMH_TYPE_DROP 3'h3
`define CMH_TYPE_LOCK 3'h4
`define CMH_TICK_NS 1000000
`define CMH_CLK_NS 25
`define CMH_RING_ON_MS 17'h0_07D0
`define CMH_RING_CYC_MS 17'h0_1770
`define CMH_RING_MAX 3'h5
`define CMH_WINDOW_MS 17'h0_7530
`define CMH_LOSS_MS 17'h0_01F4
`define CMH_MODEM_MS 17'h0_EA60
`define CMH_CALL_MS 17'h1_D4C0
`define CMH_RETRY_MAX 3'h4
`define CMH_GREET_LEN 7'h20
`define CMH_BULL_LEN 7'h78
`define CMH_PROMPT_LEN 7'h10
`endif

//--- logic/cmh_pkg.sv
// Types for the channel modem control handshake block
package cmh_pkg;
  typedef enum logic [2:0] {
    CMH_IDLE = 3'b000,
    CMH_RING = 3'b001,
    CMH_WAIT_CALL = 3'b011,
    CMH_IN_CALL = 3'b010,
    CMH_LOCKED = 3'b110,
    CMH_BUSY = 3'b111,
    CMH_WAIT_MODEM = 3'b101
  } cmh_state_type;
  typedef enum logic [1:0] {
    CMH_MSG_GREET = 2'h0,
    CMH_MSG_BULL = 2'h1,
    CMH_MSG_PROMPT = 2'h2
  } cmh_msg_type;
  typedef struct packed {
    logic dcd;
    logic dsr;
    logic cts;
    logic ring;
  } cmh_leads_type;
  typedef struct packed {
    logic dtr;
    logic rts;
    logic ri;
  } cmh_inputs_type;
endpackage

//--- logic/cmh_channel.sv
// Control-lead sequencer of one asynchronous channel
`timescale 1ns/1ps
`include "cmh_consts.svh"
// Summary of operation
// - Dial-in call clears when modem carrier or data-set-ready input drops.
// - With lead flow control, only data-set-ready loss clears a dial-in call.
// - Dial-in drops outputs without a call in two minutes or four failures.
// - Option 1 keeps carrier-detect and data-set-ready high up to two minutes after a commanded clear.
// - Option 3 drops dial-in outputs at once after a clear.
// - Ring-out channel holds every output low while idle.
// - Pulsed ringing: ring output up to five times, two seconds on, four off.
// - Terminal-ready high first, then data-set-ready and carrier-detect rise.
// - Request-to-send high next, then clear-to-send rises.
// - Pulsed call accepted only if both inputs seen within thirty seconds.
// - Ring-out clears and drops outputs when terminal-ready low over 500 ms.
// - Ring-out drops outputs whenever its call is cleared.
// - Option 4 refuses calls after a clear until terminal-ready toggles.
// - Constant ringing raises carrier first, then waits terminal-ready.
// - Priority channels have their inbound queue served first.
// - Data loss resets the circuit, or clears a switched one if set.
// - Option 32 requests accounting at the end of each call.
// - Option 64 rejects extended terminal commands.
// - Connection sends greeting with channel, bulletin, then prompt.
// - Prompt is also sent when a terminal command can be taken and no greeting or bulletin starts.
// - Unconnected inputs read inactive with bias off, active with bias on.
// - Bias is chosen per group: channels 1-4, 5-10, 11-16.
// - Connection types 0 to 7 exclusive; flags 8 to 128 combine freely.
// - Dial-in ring raises carrier-detect and data-set-ready and waits one minute for both inputs.
module cmh_channel
  import cmh_pkg::*;
#(
  parameter int CHAN = 1,
  parameter int TICK_CYCLES = `CMH_TICK_NS / `CMH_CLK_NS
) (
  input wire logic hclk, // System clock
  input wire logic hresetn, // Asynchronous reset, active low
  input wire logic hsel, // Slave select
  input wire logic [11:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write when high
  input wire logic [2:0] hsize, // Transfer size
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  output logic [31:0] hrdata, // Read data
  output logic hreadyout, // Slave ready
  output logic hresp, // Always OKAY
  input wire logic [2:0] lead_pin, // Raw dtr, rts, ri pins
  input wire logic [2:0] lead_wired, // High where a pin is connected
  output logic dcd, // Carrier detect out
  output logic dsr, // Data set ready out
  output logic cts, // Clear to send out
  output logic ring_busy_output, // Ring or busy lead
  input wire logic msg_done, // Current message sent
  input wire logic cmd_ready, // Channel can take a command
  input wire logic ext_cmd, // Extended command seen
  output logic call_accept, // Pulse: call accepted
  output logic call_refuse, // Pulse: call refused
  output logic call_clear, // Pulse: call cleared
  output logic vc_reset, // Pulse: reset circuit
  output logic vc_clear, // Pulse: clear circuit
  output logic acct_req, // Pulse: take accounting
  output logic cmd_reject, // Pulse: command refused
  output logic queue_prio, // Queue served first
  output logic msg_start, // Pulse: send a message
  output logic [1:0] msg_kind, // Message kind
  output logic [6:0] msg_len, // Message length limit
  output logic [3:0] msg_chan // Channel number for greeting
);
  // -------------------------------------------------------------
  // Bus slave
  // -------------------------------------------------------------
  logic [7:0] opt;
  logic [8:0] cfg;
  logic [4:0] cmd;
  logic wr_pend;
  logic [11:0] wr_addr;
  cmh_state_type state;
  cmh_state_type next_state;
  cmh_leads_type leads;
  cmh_leads_type next_leads;

  // Address phase decode
  wire addr_ok = hsel && hready && htrans[1];
  wire take_wr = addr_ok && hwrite;
  wire take_rd = addr_ok && !hwrite;
  wire wr_opt = wr_pend && (wr_addr == `CMH_OPT_OFS);
  wire wr_cfg = wr_pend && (wr_addr == `CMH_CFG_OFS);
  wire wr_cmd = wr_pend && (wr_addr == `CMH_CMD_OFS);
  wire [31:0] stat_word = {25'h000_0000, state, leads};
  wire [31:0] rd_word =
    (haddr == `CMH_OPT_OFS) ? {24'h00_0000, opt} :
    (haddr == `CMH_CFG_OFS) ? {23'h00_0000, cfg} :
    (haddr == `CMH_STAT_OFS) ? stat_word : 32'h0000_0000;

  // Capture write address, serve read data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 12'h000;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      wr_pend <= take_wr;
      wr_addr <= haddr;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (take_rd) begin
        hrdata <= rd_word;
      end
    end
  end

  // Option, configuration and command pulse registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      opt <= `CMH_OPT_RST;
      cfg <= `CMH_CFG_RST;
      cmd <= 5'h00;
    end else begin
      cmd <= wr_cmd ? hwdata[4:0] : 5'h00;
      if (wr_opt) begin
        opt <= hwdata[7:0];
      end
      if (wr_cfg) begin
        cfg <= hwdata[8:0];
      end
    end
  end

  // -------------------------------------------------------------
  // Option decode
  // -------------------------------------------------------------
  wire [2:0] ctype = opt[`CMH_OPT_TYPE_MSB:`CMH_OPT_TYPE_LSB];
  wire is_dial = (ctype == `CMH_TYPE_HOLD) || (ctype == `CMH_TYPE_DROP);
  wire is_ring = (ctype == `CMH_TYPE_RING) || (ctype == `CMH_TYPE_LOCK);
  wire is_ded = !is_dial && !is_ring;
  wire flow = cfg[`CMH_CFG_FLOW_BIT];
  wire ring_const = cfg[`CMH_CFG_CONST_BIT];
  wire busy_req = cfg[`CMH_CFG_BUSY_BIT];
  wire disc_req = cfg[`CMH_CFG_DISC_BIT];
  wire c_call = cmd[`CMH_CMD_CALL_BIT];
  wire c_clear = cmd[`CMH_CMD_CLEAR_BIT];
  wire c_loss = cmd[`CMH_CMD_LOSS_BIT];
  wire c_fail = cmd[`CMH_CMD_FAIL_BIT];
  wire c_est = cmd[`CMH_CMD_EST_BIT];

  // -------------------------------------------------------------
  // Input leads: synchroniser and bias
  // -------------------------------------------------------------
  logic [5:0] sync_a;
  logic [5:0] sync_b;

  // Two-stage synchroniser for pins and presence
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_a <= 6'h00;
      sync_b <= 6'h00;
    end else begin
      sync_a <= {lead_wired, lead_pin};
      sync_b <= sync_a;
    end
  end

  // Group bias by channel number
  wire [1:0] grp = (CHAN <= 4) ? 2'd0 : (CHAN <= 10) ? 2'd1 : 2'd2;
  wire [2:0] bias_bits = cfg[`CMH_CFG_BIAS_MSB:`CMH_CFG_BIAS_LSB];
  wire bias_on = bias_bits[grp];
  cmh_inputs_type lin;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_bias
      // Struct holds dtr in its top bit, the pins hold it in bit 0
      assign lin[gi] = sync_b[5 - gi] ? sync_b[2 - gi] : bias_on;
    end
  endgenerate

  // -------------------------------------------------------------
  // Millisecond tick and timers
  // -------------------------------------------------------------
  logic [31:0] div;
  logic tick;
  logic [16:0] tmr;
  logic [16:0] ph;
  logic [16:0] loss;
  logic [2:0] pulses;
  logic [2:0] tries;
  logic dtr_seen_low;
  logic dtr_q;

  // Common millisecond tick
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div <= 32'h0000_0000;
      tick <= 1'b0;
    end else begin
      tick <= (div == 32'(TICK_CYCLES - 1));
      div <= (div == 32'(TICK_CYCLES - 1)) ? 32'h0000_0000 : div + 32'h0000_0001;
    end
  end

  // Loss condition while in a call
  wire dial_drop = flow ? !lin.dtr : !(lin.dtr && lin.rts);
  wire ded_low = flow ? !lin.dtr : !(lin.dtr || lin.rts);
  wire loss_src = is_ring ? !lin.dtr : ded_low;
  wire loss_long = loss > `CMH_LOSS_MS;
  wire ring_ok = lin.dtr && (ring_const || lin.rts);
  wire win_over = tmr >= `CMH_WINDOW_MS;
  wire ded_up = flow ? lin.dtr : (lin.dtr || lin.rts);
  wire dtr_rise = lin.dtr && !dtr_q;

  // -------------------------------------------------------------
  // Channel state machine
  // -------------------------------------------------------------
  logic ev_accept;
  logic ev_refuse;
  logic ev_clear;
  always_comb begin
    next_state = state;
    ev_accept = 1'b0;
    ev_refuse = 1'b0;
    ev_clear = 1'b0;
    case (state)
      CMH_IDLE: begin
        if (busy_req || disc_req) begin
          next_state = CMH_BUSY;
        end else if (is_dial && lin.ri) begin
          next_state = CMH_WAIT_MODEM;
        end else if (c_call && is_ring) begin
          next_state = CMH_RING;
        end else if (c_call && ded_up) begin
          next_state = CMH_IN_CALL;
          ev_accept = 1'b1;
        end else if (c_call) begin
          ev_refuse = 1'b1;
        end
      end
      CMH_RING: begin
        if (ring_ok) begin
          next_state = CMH_IN_CALL;
          ev_accept = 1'b1;
        end else if (win_over) begin
          next_state = CMH_IDLE;
          ev_refuse = 1'b1;
        end
      end
      CMH_WAIT_MODEM: begin
        if (lin.dtr && lin.rts) begin
          next_state = CMH_WAIT_CALL;
        end else if (tmr >= `CMH_MODEM_MS) begin
          next_state = CMH_IDLE;
        end
      end
      CMH_WAIT_CALL: begin
        if (dial_drop) begin
          next_state = CMH_IDLE;
        end else if (c_est) begin
          next_state = CMH_IN_CALL;
          ev_accept = 1'b1;
        end else if (tmr >= `CMH_CALL_MS || tries >= `CMH_RETRY_MAX) begin
          next_state = CMH_IDLE;
        end
      end
      CMH_IN_CALL: begin
        if (is_dial && dial_drop) begin
          next_state = CMH_IDLE;
          ev_clear = 1'b1;
        end else if (!is_dial && loss_long) begin
          next_state = CMH_IDLE;
          ev_clear = 1'b1;
        end else if (c_clear || (c_loss && cfg[`CMH_CFG_CLRLOSS_BIT] && !cfg[`CMH_CFG_PVC_BIT])) begin
          ev_clear = 1'b1;
          if (ctype == `CMH_TYPE_HOLD) begin
            next_state = CMH_WAIT_CALL;
          end else begin
            next_state = CMH_IDLE;
          end
        end
        if (ev_clear && ctype == `CMH_TYPE_LOCK) begin
          next_state = CMH_LOCKED;
        end
      end
      CMH_LOCKED: begin
        if (c_call) begin
          ev_refuse = 1'b1;
        end
        if (dtr_seen_low && dtr_rise) begin
          next_state = CMH_IDLE;
        end
      end
      CMH_BUSY: begin
        if (!busy_req && !disc_req) begin
          next_state = CMH_IDLE;
        end else if (c_call) begin
          ev_refuse = 1'b1;
        end
      end
      default: begin
        next_state = CMH_IDLE;
      end
    endcase
    // Busyout waits for the call to end, disconnect does not
    if (disc_req && state != CMH_BUSY) begin
      next_state = CMH_BUSY;
      ev_clear = (state == CMH_IN_CALL);
    end
  end

  // State and timer registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= CMH_IDLE;
      tmr <= 17'h0_0000;
      ph <= 17'h0_0000;
      pulses <= 3'h0;
      tries <= 3'h0;
      loss <= 17'h0_0000;
      dtr_q <= 1'b0;
      dtr_seen_low <= 1'b0;
    end else begin
      state <= next_state;
      dtr_q <= lin.dtr;
      if (next_state != state) begin
        tmr <= 17'h0_0000;
        ph <= 17'h0_0000;
        pulses <= 3'h0;
        tries <= 3'h0;
        dtr_seen_low <= 1'b0;
      end else begin
        if (tick) begin
          tmr <= tmr + 17'h0_0001;
        end
        if (tick && ph == `CMH_RING_CYC_MS - 17'h0_0001) begin
          ph <= 17'h0_0000;
          pulses <= pulses + 3'h1;
        end else if (tick) begin
          ph <= ph + 17'h0_0001;
        end
        if (c_fail) begin
          tries <= tries + 3'h1;
        end
        if (!lin.dtr) begin
          dtr_seen_low <= 1'b1;
        end
      end
      if (state != CMH_IN_CALL || !loss_src) begin
        loss <= 17'h0_0000;
      end else if (tick && !loss_long) begin
        loss <= loss + 17'h0_0001;
      end
    end
  end

  // -------------------------------------------------------------
  // Output leads
  // -------------------------------------------------------------
  wire ring_phase = (ph < `CMH_RING_ON_MS) && (pulses < `CMH_RING_MAX);
  always_comb begin
    next_leads = '0;
    case (next_state)
      CMH_IDLE: begin
        if (is_ded) begin
          next_leads = '{dcd: 1'b1, dsr: 1'b1, cts: 1'b1, ring: 1'b0};
        end
      end
      CMH_RING: begin
        next_leads.dcd = ring_const || lin.dtr;
        next_leads.dsr = lin.dtr;
        next_leads.cts = lin.dtr && (ring_const || lin.rts);
        next_leads.ring = !ring_const && (state == CMH_RING) && ring_phase;
      end
      CMH_WAIT_MODEM, CMH_WAIT_CALL: begin
        next_leads.dcd = 1'b1;
        next_leads.dsr = 1'b1;
      end
      CMH_IN_CALL: begin
        next_leads = '{dcd: 1'b1, dsr: 1'b1, cts: 1'b1, ring: 1'b0};
      end
      CMH_BUSY: begin
        next_leads.ring = is_dial;
      end
      default: begin
        next_leads = '0;
      end
    endcase
  end

  // Register the outgoing leads
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      leads <= '0;
    end else begin
      leads <= next_leads;
    end
  end
  assign dcd = leads.dcd;
  assign dsr = leads.dsr;
  assign cts = leads.cts;
  assign ring_busy_output = leads.ring;

  // -------------------------------------------------------------
  // Call-layer events and messages
  // -------------------------------------------------------------
  wire loss_reset = c_loss && (state == CMH_IN_CALL) && (cfg[`CMH_CFG_PVC_BIT] || !cfg[`CMH_CFG_CLRLOSS_BIT]);
  wire connect = ev_accept || (state == CMH_WAIT_MODEM && next_state == CMH_WAIT_CALL);
  cmh_msg_type next_kind;
  logic next_msg;
  always_comb begin
    next_msg = 1'b0;
    next_kind = cmh_msg_type'(msg_kind);
    if (connect) begin
      next_msg = 1'b1;
      next_kind = CMH_MSG_GREET;
    end else if (msg_done && msg_kind == CMH_MSG_GREET) begin
      next_msg = 1'b1;
      next_kind = CMH_MSG_BULL;
    end else if ((msg_done && msg_kind == CMH_MSG_BULL) || cmd_ready) begin
      next_msg = 1'b1;
      next_kind = CMH_MSG_PROMPT;
    end
  end
  wire [6:0] next_len = (next_kind == CMH_MSG_GREET) ? `CMH_GREET_LEN :
    (next_kind == CMH_MSG_BULL) ? `CMH_BULL_LEN : `CMH_PROMPT_LEN;

  // Event pulses and message controls
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      call_accept <= 1'b0;
      call_refuse <= 1'b0;
      call_clear <= 1'b0;
      vc_reset <= 1'b0;
      vc_clear <= 1'b0;
      acct_req <= 1'b0;
      cmd_reject <= 1'b0;
      queue_prio <= 1'b0;
      msg_start <= 1'b0;
      msg_kind <= 2'h2;
      msg_len <= 7'h00;
      msg_chan <= 4'h0;
    end else begin
      call_accept <= ev_accept;
      call_refuse <= ev_refuse;
      call_clear <= ev_clear;
      vc_reset <= loss_reset;
      vc_clear <= c_loss && ev_clear;
      acct_req <= ev_clear && opt[`CMH_OPT_ACCT_BIT];
      cmd_reject <= ext_cmd && opt[`CMH_OPT_STD_BIT];
      queue_prio <= opt[`CMH_OPT_PRIO_BIT];
      msg_start <= next_msg;
      msg_kind <= next_kind;
      msg_len <= next_len;
      msg_chan <= 4'(CHAN);
    end
  end
endmodule

//--- verif/cmh_channel_props.sv
// Port assertions for the channel control-lead sequencer
`timescale 1ns/1ps
module cmh_channel_props
  import cmh_pkg::*;
#(
  parameter int CHAN = 1,
  parameter int TICK_CYCLES = 4
) (
  input wire logic hclk, // Clock
  input wire logic hresetn, // Reset, active low
  input wire logic hreadyout, // Slave ready
  input wire logic hresp, // Response
  input wire logic dcd, // Carrier out
  input wire logic dsr, // Set ready out
  input wire logic cts, // Clear to send out
  input wire logic ring_busy_output, // Ring lead
  input wire logic cmd_ready, // Command can be taken
  input wire logic call_accept, // Accept pulse
  input wire logic call_refuse, // Refuse pulse
  input wire logic cmd_reject, // Reject pulse
  input wire logic msg_start, // Message start
  input wire logic [1:0] msg_kind, // Message kind
  input wire logic [6:0] msg_len, // Message limit
  input wire logic [3:0] msg_chan // Channel number
);
  localparam int RING_ON = 2000 * TICK_CYCLES;
  int ring_len;
  // ----------------
  // Ring pulse length
  // ----------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      ring_len <= 0;
    else if (ring_busy_output)
      ring_len <= ring_len + 1;
    else
      ring_len <= 0;
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_ok; $past(hresetn) |-> hreadyout && !hresp; endproperty
  a_ok: assert property (p_ok) else $error("bus not ready or not okay");
  property p_cts_order; $rose(cts) |-> dsr && dcd; endproperty
  a_cts_order: assert property (p_cts_order) else $error("cts before dsr and dcd");
  property p_accept_once; call_accept |=> !call_accept; endproperty
  a_accept_once: assert property (p_accept_once) else $error("accept not a pulse");
  property p_accept_leads; call_accept |-> ##[0:2] (dcd && dsr && cts); endproperty
  a_accept_leads: assert property (p_accept_leads) else $error("accept without leads");
  property p_greet;
    call_accept |-> ##[0:2] (msg_start && msg_kind == CMH_MSG_GREET && msg_len == 7'h20 && msg_chan == 4'(CHAN));
  endproperty
  a_greet: assert property (p_greet) else $error("no greeting after accept");
  property p_prompt; cmd_ready |=> msg_start && msg_kind == CMH_MSG_PROMPT && msg_len == 7'h10; endproperty
  a_prompt: assert property (p_prompt) else $error("no prompt on command ready");
  property p_refuse; call_refuse |-> ##[0:2] !(dcd || dsr || cts); endproperty
  a_refuse: assert property (p_refuse) else $error("leads up after refusal");
  property p_ring_on; $fell(ring_busy_output) && !dcd |-> ring_len == RING_ON; endproperty
  a_ring_on: assert property (p_ring_on) else $error("ring pulse length wrong");
  c_accept: cover property (call_accept);
  c_refuse: cover property (call_refuse);
  c_reject: cover property (cmd_reject);
endmodule
bind cmh_channel cmh_channel_props #(.CHAN(CHAN), .TICK_CYCLES(TICK_CYCLES)) u_props (.hclk, .hresetn,
  .hreadyout, .hresp, .dcd, .dsr, .cts, .ring_busy_output, .cmd_ready, .call_accept, .call_refuse,
  .cmd_reject, .msg_start, .msg_kind, .msg_len, .msg_chan);

//--- verif/cmh_term.sv
// Attached terminal port model
`timescale 1ns/1ps
module cmh_term (
  input wire logic hclk, // Clock
  input wire logic answer, // Answer incoming calls
  input wire logic dtr_hold, // Terminal-ready when not answering
  input wire logic dcd, // Carrier from channel
  input wire logic dsr, // Set ready from channel
  input wire logic ring_busy_output, // Ring from channel
  output logic [2:0] lead_pin, // {ri, rts, dtr}
  output logic [2:0] lead_wired // All leads cabled
);
  logic dtr = 1'b0;
  logic rts = 1'b0;
  assign lead_wired = 3'h7;
  assign lead_pin = {1'b0, rts, dtr};
  // Terminal-ready answers ring or carrier
  always @(posedge hclk) begin
    if (!answer)
      dtr <= dtr_hold;
    else if (ring_busy_output || dcd)
      dtr <= 1'b1;
  end
  // Request-to-send once set-ready and carrier are up
  always @(posedge hclk) rts <= answer && dsr && dcd;
endmodule

//--- verif/tb_top.sv
// Testbench for the channel control-lead sequencer
`timescale 1ns/1ps
`define CHK(nm, e, a) begin check_count++; if ((a) !== (e)) begin failures++; \
  $display("wrong value %s expected %h seen %h", nm, e, a); end end
module tb_top;
  import cmh_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic [11:0] haddr = 12'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic msg_done = 1'b0;
  logic cmd_ready = 1'b0;
  logic ext_cmd = 1'b0;
  logic answer = 1'b0;
  logic dtr_hold = 1'b0;
  logic [31:0] hrdata, rdv;
  logic hreadyout, hresp, dcd, dsr, cts, ring_busy_output, queue_prio, msg_start;
  logic call_accept, call_refuse, call_clear, vc_reset, vc_clear, acct_req, cmd_reject;
  logic [1:0] msg_kind, kind;
  logic [6:0] msg_len, len;
  logic [3:0] msg_chan;
  logic [2:0] lead_pin, lead_wired;
  logic [7:0] ev, seen;
  int failures = 0;
  int check_count = 0;
  int n, r;
  assign ev = {call_accept, call_refuse, call_clear, vc_reset, vc_clear, acct_req, cmd_reject, msg_start};
  always #12.5 hclk = ~hclk;
  cmh_channel #(.CHAN(5), .TICK_CYCLES(1)) dut_u (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .lead_pin, .lead_wired, .dcd,
    .dsr, .cts, .ring_busy_output, .msg_done, .cmd_ready, .ext_cmd, .call_accept, .call_refuse, .call_clear,
    .vc_reset, .vc_clear, .acct_req, .cmd_reject, .queue_prio, .msg_start, .msg_kind, .msg_len, .msg_chan);
  cmh_term term_u (.hclk, .answer, .dtr_hold, .dcd, .dsr, .ring_busy_output, .lead_pin, .lead_wired);
  // ----------------
  // Bus and event helpers
  // ----------------
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge hclk);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdv = hrdata;
  endtask
  task watch(input int lim, input logic [7:0] stop);
    logic prev;
    seen = 8'h0;
    n = 0;
    r = 0;
    kind = 2'bx;
    len = 7'bx;
    prev = ring_busy_output;
    while (!(|(seen & stop)) && n < lim) begin
      @(posedge hclk);
      n++;
      seen |= ev;
      if (msg_start === 1'b1) begin
        kind = msg_kind;
        len = msg_len;
      end
      if (ring_busy_output === 1'b1 && prev !== 1'b1) r++;
      prev = ring_busy_output;
    end
  endtask
  task poke(input logic [2:0] p);
    {ext_cmd, cmd_ready, msg_done} <= p;
    @(posedge hclk);
    {ext_cmd, cmd_ready, msg_done} <= 3'h0;
    watch(4, 8'h0);
  endtask
  task end_sim;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ----------------
  // Scenarios
  // ----------------
  task t_regs;
    bus(0, 12'h0, 32'h0);
    `CHK("opt reset", 32'h0, rdv)
    bus(0, 12'h4, 32'h0);
    `CHK("cfg reset", 32'h0, rdv)
    bus(1, 12'h0, 32'h74);
    bus(0, 12'h0, 32'h0);
    `CHK("opt", 32'h74, rdv)
    bus(1, 12'h10, 32'hFF);
    bus(0, 12'h10, 32'h0);
    `CHK("unmapped", 32'h0, rdv)
    repeat (4) @(posedge hclk);
    `CHK("priority", 1'b1, queue_prio)
    `CHK("idle leads", 4'h0, {dcd, dsr, cts, ring_busy_output})
  endtask
  task t_call;
    answer <= 1'b1;
    bus(1, 12'h8, 32'h1);
    watch(3000, 8'h80);
    `CHK("accept", 1'b1, seen[7])
    `CHK("call leads", 3'h7, {dcd, dsr, cts})
    poke(3'h1);
    `CHK("bulletin", {CMH_MSG_BULL, 7'h78}, {kind, len})
    poke(3'h1);
    `CHK("prompt", {CMH_MSG_PROMPT, 7'h10}, {kind, len})
    poke(3'h2);
    `CHK("ready prompt", {CMH_MSG_PROMPT, 7'h10}, {kind, len})
    poke(3'h4);
    `CHK("reject", 1'b1, seen[1])
    bus(1, 12'h8, 32'h4);
    watch(6, 8'h0);
    `CHK("loss reset", 2'h2, seen[4:3])
  endtask
  task t_loss;
    answer <= 1'b0;
    watch(2000, 8'h20);
    `CHK("loss time", 1'b1, (n > 500) && (n <= 515))
    `CHK("accounting", 1'b1, seen[2])
    watch(4, 8'h0);
    `CHK("leads dropped", 4'h0, {dcd, dsr, cts, ring_busy_output})
  endtask
  task t_lock;
    bus(1, 12'h8, 32'h1);
    watch(200, 8'h40);
    `CHK("locked refuse", 1'b1, seen[6])
    `CHK("locked rings", 0, r)
    dtr_hold <= 1'b1;
    repeat (6) @(posedge hclk);
    dtr_hold <= 1'b0;
    repeat (6) @(posedge hclk);
  endtask
  task t_window;
    bus(1, 12'h8, 32'h1);
    watch(32000, 8'h40);
    `CHK("window refuse", 1'b1, seen[6])
    `CHK("ring count", 5, r)
    `CHK("window time", 1'b1, (n >= 29990) && (n <= 30010))
  endtask
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    t_regs;
    t_call;
    t_loss;
    t_lock;
    t_window;
    end_sim;
  end
  // Watchdog against a hang
  initial begin
    repeat (40000) @(posedge hclk);
    failures++;
    end_sim;
  end
endmodule
